//--- logic/lrpc_pkg.sv
// Package: constants and carrier types for the display refresh block
package lrpc_pkg;
	// ----------------------------------------
	// Register map (word indices)
	// ----------------------------------------
	localparam logic [2:0] REG_START = 3'h0;
	localparam logic [2:0] REG_LINE_OFS = 3'h1;
	localparam logic [2:0] REG_ROW_CNT = 3'h2;
	localparam logic [2:0] REG_SEC_START = 3'h3;
	localparam logic [2:0] REG_BIT_SHIFT = 3'h4;
	localparam logic [2:0] REG_CONTRAST = 3'h5;
	localparam logic [2:0] REG_TEST = 3'h6;
	// ----------------------------------------
	// Widths, field positions, reset values
	// ----------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 20;
	localparam int OFS_W = 12;
	localparam int CNT_W = 2;
	localparam int HALF_MUX_BIT = 2;
	localparam int REMAP_BIT = 3;
	localparam int SHIFT_W = 3;
	localparam int DON_BIT = 3;
	localparam int CONTRAST_W = 5;
	localparam int TEST_W = 7;
	localparam logic [ADDR_W-1:0] START_RST = 20'h00000;
	localparam logic [OFS_W-1:0] OFS_RST = 12'h000;
	localparam logic [3:0] ROW_CNT_RST = 4'h0;
	localparam logic [3:0] BIT_SHIFT_RST = 4'h0;
	localparam logic [CONTRAST_W-1:0] CONTRAST_RST = 5'h00;
	localparam logic [TEST_W-1:0] TEST_RST = 7'h00;
	// ----------------------------------------
	// Display geometry
	// ----------------------------------------
	localparam int COLS = 128;
	localparam int ROWS_FULL = 64;
	localparam int ROWS_HALF = 32;
	localparam int ROW_BYTES = 16;
	localparam int PAIRS = 64;
	localparam logic [SHIFT_W-1:0] EXTRA_BYTE_ABOVE = 3'h3;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 4;
	localparam int ROW_TIME_NS = 244000;
	localparam int ROW_CYC = ROW_TIME_NS / CLK_NS;
	localparam int SHIFT_HALF_NS = 200;
	localparam int SHIFT_HALF_CYC = SHIFT_HALF_NS / CLK_NS;
	localparam int LATCH_NS = 40;
	localparam int LATCH_CYC = LATCH_NS / CLK_NS;
	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] column_data_pair;
		logic column_shift_clock;
		logic row_latch_pulse;
		logic frame_polarity;
	} lrpc_col_t;
	typedef struct packed {
		logic req;
		logic [ADDR_W-1:0] addr;
	} lrpc_mem_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_SHIFT
	} lrpc_state_t;
endpackage

//--- logic/lrpc_top.sv
// Display refresh pointer and column driver output logic
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// Overview of operation
// - Start address bit zero ignored
// - Frame start loads pointer from start address
// - Row end adds sign-extended even offset
// - Counter write holds; load frame, decrement row
// - Counter read returns live count
// - Count zero loads secondary address next row
// - After secondary load, no more offsets
// - Next frame restores start, re-enables offset
// - Secondary rows are count plus two onward
// - Primary frame load beats secondary load
// - Counter bit 2 selects 32-way multiplex
// - Counter bit 3 remaps third chip enable
// - Fetched bytes shifted by 3-bit offset
// - Offset above three fetches extra byte
// - Bit-shift register MSB turns display on
// - Five-bit contrast, larger is darker
// - Seven-bit test register, zero normally
// - 128 columns, two bits per shift
// - Frame polarity output sets drive polarity
// - 64 rows, 244 us each, 64 Hz
// - Pointer advances one per byte read
// - Row start requests next row's data
module lrpc_top #(
	parameter int ROW_CYCLES = lrpc_pkg::ROW_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Register port
	input wire logic [2:0] i_reg_addr,
	input wire logic [lrpc_pkg::DATA_W-1:0] i_reg_wdata,
	input wire logic i_reg_write,
	input wire logic i_reg_read,
	output logic [lrpc_pkg::DATA_W-1:0] o_reg_rdata,
	// Display memory fetch
	output lrpc_pkg::lrpc_mem_t o_mem,
	input wire logic i_mem_ack,
	input wire logic [7:0] i_mem_data,
	// Chip enable remap
	input wire logic i_third_chip_enable_n,
	input wire logic i_address_bit_eighteen,
	output logic o_third_chip_enable_n,
	// Column driver link and analog controls
	output lrpc_pkg::lrpc_col_t o_col,
	output logic o_display_on,
	output logic [lrpc_pkg::CONTRAST_W-1:0] o_contrast,
	output logic [lrpc_pkg::TEST_W-1:0] o_test_mode
);
	localparam int AW = lrpc_pkg::ADDR_W;
	localparam int BUF_W = (lrpc_pkg::ROW_BYTES + 1) * 8;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_reg;
	logic rst_n_reg;

	// Async assert, release through two flops
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [AW-1:0] start_reg;
	logic [AW-1:0] sec_start_reg;
	logic [lrpc_pkg::OFS_W-1:0] line_ofs_reg;
	logic [lrpc_pkg::CNT_W-1:0] cnt_hold_reg;
	logic half_mux_reg;
	logic remap_reg;
	logic [3:0] bit_shift_reg;
	logic [lrpc_pkg::CONTRAST_W-1:0] contrast_reg;
	logic [lrpc_pkg::TEST_W-1:0] test_reg;
	logic [lrpc_pkg::CNT_W-1:0] cnt_reg;

	// Software writes
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			start_reg <= lrpc_pkg::START_RST;
			sec_start_reg <= lrpc_pkg::START_RST;
			line_ofs_reg <= lrpc_pkg::OFS_RST;
			cnt_hold_reg <= lrpc_pkg::ROW_CNT_RST[1:0];
			half_mux_reg <= lrpc_pkg::ROW_CNT_RST[2];
			remap_reg <= lrpc_pkg::ROW_CNT_RST[3];
			bit_shift_reg <= lrpc_pkg::BIT_SHIFT_RST;
			contrast_reg <= lrpc_pkg::CONTRAST_RST;
			test_reg <= lrpc_pkg::TEST_RST;
		end else if (i_reg_write) begin
			unique case (i_reg_addr)
				lrpc_pkg::REG_START: start_reg <= i_reg_wdata;
				lrpc_pkg::REG_LINE_OFS:
					line_ofs_reg <= i_reg_wdata[11:0];
				lrpc_pkg::REG_ROW_CNT: begin
					cnt_hold_reg <= i_reg_wdata[1:0];
					half_mux_reg <= i_reg_wdata[2];
					remap_reg <= i_reg_wdata[3];
				end
				lrpc_pkg::REG_SEC_START:
					sec_start_reg <= i_reg_wdata;
				lrpc_pkg::REG_BIT_SHIFT:
					bit_shift_reg <= i_reg_wdata[3:0];
				lrpc_pkg::REG_CONTRAST:
					contrast_reg <= i_reg_wdata[4:0];
				lrpc_pkg::REG_TEST:
					test_reg <= i_reg_wdata[6:0];
				default: ;
			endcase
		end
	end

	// Reads answer the next cycle; unmapped reads return zero
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_reg_rdata <= '0;
		end else if (i_reg_read) begin
			unique case (i_reg_addr)
				lrpc_pkg::REG_START: o_reg_rdata <= start_reg;
				lrpc_pkg::REG_LINE_OFS:
					o_reg_rdata <= {8'h00, line_ofs_reg};
				lrpc_pkg::REG_ROW_CNT: o_reg_rdata <= {16'h0000,
					remap_reg, half_mux_reg, cnt_reg};
				lrpc_pkg::REG_SEC_START:
					o_reg_rdata <= sec_start_reg;
				lrpc_pkg::REG_BIT_SHIFT:
					o_reg_rdata <= {16'h0000, bit_shift_reg};
				lrpc_pkg::REG_CONTRAST:
					o_reg_rdata <= {15'h0000, contrast_reg};
				lrpc_pkg::REG_TEST:
					o_reg_rdata <= {13'h0000, test_reg};
				default: o_reg_rdata <= '0;
			endcase
		end else begin
			o_reg_rdata <= '0;
		end
	end

	// ----------------------------------------
	// Row timer and frame sequencing
	// ----------------------------------------
	logic [$clog2(ROW_CYCLES)-1:0] row_tmr_reg;
	logic [5:0] row_idx_reg;
	logic row_tick;
	logic frame_start;
	logic display_on;
	logic [5:0] last_row;

	assign display_on = bit_shift_reg[lrpc_pkg::DON_BIT];
	assign last_row = half_mux_reg ? 6'(lrpc_pkg::ROWS_HALF - 1)
		: 6'(lrpc_pkg::ROWS_FULL - 1);
	assign row_tick = (row_tmr_reg == '0);
	assign frame_start = row_tick && (row_idx_reg == '0);

	// One row period per tick, rows wrap per frame
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			row_tmr_reg <= '0;
			row_idx_reg <= '0;
		end else if (row_tick) begin
			row_tmr_reg <= ($clog2(ROW_CYCLES))'(ROW_CYCLES - 1);
			row_idx_reg <= (row_idx_reg >= last_row) ? 6'h00
				: row_idx_reg + 6'h01;
		end else begin
			row_tmr_reg <= row_tmr_reg - 1'b1;
		end
	end

	// ----------------------------------------
	// Fetch, shift and pointer control
	// ----------------------------------------
	lrpc_pkg::lrpc_state_t state_reg;
	logic [AW-1:0] ptr_reg;
	logic ofs_en_reg;
	logic [4:0] byte_cnt_reg;
	logic [4:0] bytes_needed;
	logic [BUF_W-1:0] fetch_buf_reg;
	logic [lrpc_pkg::COLS-1:0] col_sh_reg;
	logic [BUF_W-1:0] aligned;
	logic [AW-1:0] ofs_ext;
	logic [5:0] pair_cnt_reg;
	logic [$clog2(lrpc_pkg::SHIFT_HALF_CYC)-1:0] div_reg;
	logic half_en;
	logic row_done;
	logic [BUF_W-1:0] fetch_full;
	// Link outputs live in plain flops and are packed onto the port below
	logic sclk_reg;
	logic [1:0] pair_reg;
	logic latch_reg;
	logic pol_reg;

	// Extra byte needed when bits spill over
	assign bytes_needed = (bit_shift_reg[2:0] > lrpc_pkg::EXTRA_BYTE_ABOVE)
		? 5'(lrpc_pkg::ROW_BYTES + 1) : 5'(lrpc_pkg::ROW_BYTES);
	// Bit zero dropped, top bit extended
	assign ofs_ext = {{(AW - lrpc_pkg::OFS_W){line_ofs_reg[11]}},
		line_ofs_reg[11:1], 1'b0};
	// The last byte lands in the same cycle as row_done; fold it in here
	// so the rightmost columns never come from a stale buffer slot
	always_comb begin
		fetch_full = fetch_buf_reg;
		if (row_done)
			fetch_full[byte_cnt_reg * 8 +: 8] = i_mem_data;
	end
	assign aligned = fetch_full >> bit_shift_reg[2:0];
	// At or past the last byte, so an offset change mid-row cannot hang
	assign row_done = (state_reg == lrpc_pkg::ST_FETCH) && i_mem_ack
		&& (byte_cnt_reg >= bytes_needed - 5'h01);
	assign half_en = (div_reg == '0);

	// Sequencer: fetch the row, then shift it out
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg <= lrpc_pkg::ST_IDLE;
			byte_cnt_reg <= '0;
		end else if (row_tick) begin
			// A late row is abandoned so timing never slips
			state_reg <= display_on ? lrpc_pkg::ST_FETCH
				: lrpc_pkg::ST_IDLE;
			byte_cnt_reg <= '0;
		end else begin
			unique case (state_reg)
				lrpc_pkg::ST_IDLE: ;
				lrpc_pkg::ST_FETCH:
					if (i_mem_ack) begin
						byte_cnt_reg <= byte_cnt_reg + 5'h01;
						if (row_done)
							state_reg <= lrpc_pkg::ST_SHIFT;
					end
				lrpc_pkg::ST_SHIFT:
					if (half_en && sclk_reg
						&& pair_cnt_reg == 6'(lrpc_pkg::PAIRS - 1))
						state_reg <= lrpc_pkg::ST_IDLE;
			endcase
		end
	end

	// Incoming bytes packed little end first: bit 0 is leftmost
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			fetch_buf_reg <= '0;
		end else if (row_tick) begin
			fetch_buf_reg <= '0;
		end else if (state_reg == lrpc_pkg::ST_FETCH && i_mem_ack) begin
			fetch_buf_reg[byte_cnt_reg * 8 +: 8] <= i_mem_data;
		end
	end

	// Pointer: frame load, byte step, row end step or reload
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ptr_reg <= '0;
			ofs_en_reg <= 1'b1;
			cnt_reg <= '0;
		end else if (frame_start) begin
			// Frame load wins over any pending reload
			ptr_reg <= {start_reg[AW-1:1], 1'b0};
			ofs_en_reg <= 1'b1;
			cnt_reg <= cnt_hold_reg;
		end else if (row_done) begin
			if (ofs_en_reg && cnt_reg == '0) begin
				// Next row, number count plus two, uses secondary
				ptr_reg <= {sec_start_reg[AW-1:1], 1'b0};
				ofs_en_reg <= 1'b0;
			end else if (ofs_en_reg) begin
				ptr_reg <= ptr_reg + 20'h00001 + ofs_ext;
			end else begin
				ptr_reg <= ptr_reg + 20'h00001;
			end
			if (cnt_reg != '0)
				cnt_reg <= cnt_reg - 1'b1;
		end else if (state_reg == lrpc_pkg::ST_FETCH && i_mem_ack) begin
			ptr_reg <= ptr_reg + 20'h00001;
		end
	end

	assign o_mem = '{req: (state_reg == lrpc_pkg::ST_FETCH),
		addr: ptr_reg};

	// ----------------------------------------
	// Column shift clock divider
	// ----------------------------------------
	// Enable pulse every half shift period while shifting
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			div_reg <= '0;
		end else if (state_reg != lrpc_pkg::ST_SHIFT || half_en) begin
			div_reg <= ($clog2(lrpc_pkg::SHIFT_HALF_CYC))'(
				lrpc_pkg::SHIFT_HALF_CYC - 1);
		end else begin
			div_reg <= div_reg - 1'b1;
		end
	end

	// ----------------------------------------
	// Column data output
	// ----------------------------------------
	// Data settles while clock is low, changes right after fall
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			col_sh_reg <= '0;
			pair_cnt_reg <= '0;
			sclk_reg <= 1'b0;
			pair_reg <= 2'h0;
		end else if (row_done) begin
			col_sh_reg <= aligned[lrpc_pkg::COLS-1:0];
			pair_cnt_reg <= '0;
			pair_reg <= aligned[1:0];
		end else if (state_reg == lrpc_pkg::ST_SHIFT && half_en) begin
			sclk_reg <= ~sclk_reg;
			if (sclk_reg) begin
				// Falling edge: driver has sampled this pair
				col_sh_reg <= col_sh_reg >> 2;
				pair_cnt_reg <= pair_cnt_reg + 6'h01;
				pair_reg <= col_sh_reg[3:2];
			end
		end else if (state_reg != lrpc_pkg::ST_SHIFT) begin
			sclk_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Latch pulse and frame polarity
	// ----------------------------------------
	logic [$clog2(lrpc_pkg::LATCH_CYC+1)-1:0] latch_cnt_reg;

	// Latch row shifted during the previous row; flip polarity per frame
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			latch_cnt_reg <= '0;
			latch_reg <= 1'b0;
			pol_reg <= 1'b0;
		end else begin
			if (row_tick) begin
				latch_cnt_reg <= ($clog2(lrpc_pkg::LATCH_CYC+1))'(
					lrpc_pkg::LATCH_CYC);
				latch_reg <= 1'b1;
			end else if (latch_cnt_reg > 1) begin
				latch_cnt_reg <= latch_cnt_reg - 1'b1;
			end else begin
				latch_cnt_reg <= '0;
				latch_reg <= 1'b0;
			end
			if (frame_start)
				pol_reg <= ~pol_reg;
		end
	end

	// ----------------------------------------
	// Side outputs
	// ----------------------------------------
	// Inverted address lets cold start remap before use
	assign o_third_chip_enable_n = remap_reg ? ~i_address_bit_eighteen
		: i_third_chip_enable_n;
	assign o_display_on = display_on;
	assign o_contrast = contrast_reg;
	assign o_test_mode = test_reg;

	// One assignment for the whole link carrier keeps a single driver
	assign o_col = '{column_data_pair: pair_reg,
		column_shift_clock: sclk_reg,
		row_latch_pulse: latch_reg,
		frame_polarity: pol_reg};
endmodule // lrpc_top

//--- tb/lrpc_mem_model.sv
// Display memory and column driver model
`timescale 1ns/100ps
module lrpc_mem_model (
	// Clock and pacing
	input wire logic i_clk,
	input wire logic i_slow,
	// Fetch port
	input wire lrpc_pkg::lrpc_mem_t i_mem,
	output logic o_ack,
	output logic [7:0] o_data,
	// Column link
	input wire lrpc_pkg::lrpc_col_t i_col
);
	// ----------------------------------------
	// Memory and capture
	// ----------------------------------------
	logic tog = 1'b0;
	logic req_q = 1'b0;
	logic lp_q = 1'b0;
	logic sclk_q = 1'b0;
	logic pol_seen = 1'b0;
	logic [1:0] pair_q = 2'h0;
	logic [7:0] dq = 8'h00;
	int r = 0;
	int f = 0;
	logic [19:0] row_addr [64];
	int nbytes [64];
	logic [1:0] cap [64];
	// Slow pacing answers only every other cycle
	assign o_ack = i_mem.req & (~i_slow | tog);
	// Idle data is the inverse of the previous cycle's data, never stale
	assign o_data = o_ack ? (i_mem.addr[7:0] ^ 8'h5A) : ~dq;
	// Log each row fetch and the pairs shifted into the driver
	always @(posedge i_clk) begin
		tog <= ~tog;
		req_q <= i_mem.req;
		lp_q <= i_col.row_latch_pulse;
		sclk_q <= i_col.column_shift_clock;
		pair_q <= i_col.column_data_pair;
		dq <= o_data;
		if (i_mem.req && !req_q) begin
			r = (i_col.frame_polarity != pol_seen) ? 0 : r + 1;
			pol_seen <= i_col.frame_polarity;
			row_addr[r] <= i_mem.addr;
			nbytes[r] <= int'(o_ack);
		end else if (o_ack)
			nbytes[r] <= nbytes[r] + 1;
		if (sclk_q && !i_col.column_shift_clock && f < 64) begin
			cap[f] <= pair_q;
			f <= f + 1;
		end
		if (lp_q && !i_col.row_latch_pulse)
			f <= 0;
	end
endmodule // lrpc_mem_model

//--- tb/lrpc_top_assertions.sv
// Checker: port properties of the display refresh block
`timescale 1ns/100ps
module lrpc_top_checker (
	// Clock, reset and register writes
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [2:0] i_reg_addr,
	input wire logic [19:0] i_reg_wdata,
	input wire logic i_reg_write,
	// Fetch, remap and outputs
	input wire lrpc_pkg::lrpc_mem_t o_mem,
	input wire logic i_mem_ack,
	input wire logic i_third_chip_enable_n,
	input wire logic i_address_bit_eighteen,
	input wire logic o_third_chip_enable_n,
	input wire lrpc_pkg::lrpc_col_t o_col,
	input wire logic o_display_on,
	input wire logic [4:0] o_contrast
);
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	logic remap_q;
	logic [2:0] ofs_q;
	logic [4:0] n_ack;
	// Mirror the mode bits that steer the checks below
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			remap_q <= 1'b0;
			ofs_q <= 3'h0;
		end else if (i_reg_write) begin
			if (i_reg_addr == lrpc_pkg::REG_ROW_CNT)
				remap_q <= i_reg_wdata[3];
			if (i_reg_addr == lrpc_pkg::REG_BIT_SHIFT)
				ofs_q <= i_reg_wdata[2:0];
		end
	end
	// Bytes taken in the current row fetch, cleared while idle
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			n_ack <= 5'h00;
		else if (!o_mem.req)
			n_ack <= 5'h00;
		else if (i_mem_ack)
			n_ack <= n_ack + 5'h01;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_ack;
		o_mem.req && i_mem_ack;
	endsequence
	property p_addr_step;
		s_ack ##1 o_mem.req |-> o_mem.addr == $past(o_mem.addr) + 20'h00001;
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("fetch address did not step");
	// A short row would leave shifted bits from stale data
	property p_fetch_len;
		$fell(o_mem.req) |-> n_ack == ((ofs_q > 3'h3) ? 5'h11 : 5'h10);
	endproperty
	a_fetch_len: assert property (p_fetch_len)
		else $error("wrong byte count per row");
	property p_fetch_after_tick;
		$rose(o_col.row_latch_pulse) && o_display_on |-> ##[0:2] o_mem.req;
	endproperty
	a_fetch_after_tick: assert property (p_fetch_after_tick)
		else $error("no fetch at row start");
	property p_polarity;
		$changed(o_col.frame_polarity) |-> o_col.row_latch_pulse;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("polarity moved outside a row tick");
	property p_pair_stable;
		o_col.column_shift_clock && $past(o_col.column_shift_clock)
			|-> $stable(o_col.column_data_pair);
	endproperty
	a_pair_stable: assert property (p_pair_stable)
		else $error("column pair moved while clock high");
	property p_remap;
		o_third_chip_enable_n == (remap_q ? !i_address_bit_eighteen
			: i_third_chip_enable_n);
	endproperty
	a_remap: assert property (p_remap)
		else $error("third chip enable wrong");
	property p_contrast;
		i_reg_write && i_reg_addr == lrpc_pkg::REG_CONTRAST
			|=> o_contrast == $past(i_reg_wdata[4:0]);
	endproperty
	a_contrast: assert property (p_contrast)
		else $error("contrast not updated");
	property p_don;
		i_reg_write && i_reg_addr == lrpc_pkg::REG_BIT_SHIFT
			|=> o_display_on == $past(i_reg_wdata[3]);
	endproperty
	a_don: assert property (p_don)
		else $error("display on not updated");
endmodule // lrpc_top_checker
bind lrpc_top lrpc_top_checker u_chk (.i_clk, .i_reset_n, .i_reg_addr,
	.i_reg_wdata, .i_reg_write, .o_mem, .i_mem_ack, .i_third_chip_enable_n,
	.i_address_bit_eighteen, .o_third_chip_enable_n, .o_col, .o_display_on,
	.o_contrast);

//--- tb/testbench.sv
// Testbench: register access, row fetch and column link
`timescale 1ns/100ps
module testbench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int RC = 700;
	localparam logic [19:0] ROWS [6] = '{20'h01000, 20'h0100F,
		20'h0101E, 20'h02002, 20'h02013, 20'h02024};
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [2:0] i_reg_addr = 3'h0;
	logic [19:0] i_reg_wdata = 20'h00000;
	logic i_reg_write = 1'b0;
	logic i_reg_read = 1'b0;
	logic [19:0] o_reg_rdata;
	lrpc_pkg::lrpc_mem_t o_mem;
	logic i_mem_ack;
	logic [7:0] i_mem_data;
	logic i_third_chip_enable_n = 1'b1;
	logic i_address_bit_eighteen = 1'b0;
	logic o_third_chip_enable_n;
	lrpc_pkg::lrpc_col_t o_col;
	logic o_display_on;
	logic [4:0] o_contrast;
	logic [6:0] o_test_mode;
	logic slow = 1'b0;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	int t1 = 0;
	lrpc_top #(.ROW_CYCLES(RC)) u_lrpc_top (.i_clk, .i_reset_n, .i_reg_addr,
		.i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata, .o_mem,
		.i_mem_ack, .i_mem_data, .i_third_chip_enable_n,
		.i_address_bit_eighteen, .o_third_chip_enable_n, .o_col,
		.o_display_on, .o_contrast, .o_test_mode);
	lrpc_mem_model u_lrpc_mem_model (.i_clk, .i_slow(slow), .i_mem(o_mem),
		.o_ack(i_mem_ack), .o_data(i_mem_data), .i_col(o_col));
	// Clock
	initial forever #2 i_clk = ~i_clk;
	// Cycle count, chip-enable stimulus and hang guard
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		i_address_bit_eighteen <= cyc[0];
		i_third_chip_enable_n <= cyc[1];
		if (cyc == 80000) begin
			n_errors++;
			results();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic results;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [19:0] e, g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [19:0] v);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_wdata <= v;
		i_reg_write <= 1'b1;
		@(posedge i_clk);
		i_reg_write <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [2:0] a, logic [19:0] e);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_read <= 1'b1;
		@(posedge i_clk);
		i_reg_read <= 1'b0;
		#1 chk(n, e, o_reg_rdata);
	endtask
	// Pair k of a row at address p, bit offset 4, byte k fills bits 8k up
	function automatic logic [1:0] e_pair(input logic [19:0] p, int k);
		logic [1:0] v;
		logic [7:0] m;
		int i;
		for (int b = 0; b < 2; b++) begin
			i = 2 * k + b + 4;
			m = (p[7:0] + 8'(i / 8)) ^ 8'h5A;
			v[b] = m[i % 8];
		end
		return v;
	endfunction
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		for (int a = 0; a < 8; a++)
			rchk("reset value", 3'(a), 20'h00000);
		wr(lrpc_pkg::REG_START, 20'h01001);
		wr(lrpc_pkg::REG_LINE_OFS, 20'hFFFFF);
		wr(lrpc_pkg::REG_ROW_CNT, 20'h0000E);
		wr(lrpc_pkg::REG_SEC_START, 20'h02003);
		wr(lrpc_pkg::REG_CONTRAST, 20'hFFFFF);
		wr(lrpc_pkg::REG_TEST, 20'hFFFFF);
		rchk("contrast", lrpc_pkg::REG_CONTRAST, 20'h0001F);
		rchk("test", lrpc_pkg::REG_TEST, 20'h0007F);
		chk("test out", 20'h0007F, 20'(o_test_mode));
		wr(lrpc_pkg::REG_TEST, 20'h00000);
		wr(lrpc_pkg::REG_BIT_SHIFT, 20'h0000C);
		#1 chk("display on", 20'h00001, 20'(o_display_on));
		while (o_col.frame_polarity !== 1'b0) @(posedge i_clk);
		t1 = cyc;
		repeat (RC / 2) @(posedge i_clk);
		rchk("live count", lrpc_pkg::REG_ROW_CNT, 20'h0000D);
		for (int k = 0; k < 3; k++)
			chk("pair", 20'(e_pair(20'h01000, k)), 20'(u_lrpc_mem_model.cap[k]));
		while (cyc < t1 + 6 * RC) @(posedge i_clk);
		for (int r = 0; r < 6; r++) begin
			chk("row address", ROWS[r], u_lrpc_mem_model.row_addr[r]);
			chk("row bytes", 20'h00011, 20'(u_lrpc_mem_model.nbytes[r]));
		end
		slow <= 1'b1;
		wr(lrpc_pkg::REG_ROW_CNT, 20'h00004);
		while (o_col.frame_polarity !== 1'b1) @(posedge i_clk);
		chk("frame length", 20'(32 * RC), 20'(cyc - t1));
		t1 = cyc;
		while (cyc < t1 + 2 * RC) @(posedge i_clk);
		chk("first row", 20'h01000, u_lrpc_mem_model.row_addr[0]);
		chk("second row", 20'h02002, u_lrpc_mem_model.row_addr[1]);
		chk("slow bytes", 20'h00011, 20'(u_lrpc_mem_model.nbytes[0]));
		results();
	end
endmodule // testbench
